// >>> hdl/lcdcm_top.v
// Character and bit mapper for a segment LCD: manual glyph writes,
// DMA-fed string and bitmap engines, frame counters, shadow memory.
// Assumes frame_start is a one-cycle pulse from logic on ref_clk and the
// DMA controller writes the data registers over the same register port.
//
// Notes on behaviour
// R01: Four selectable glyph tables chosen by the glyph configuration register.
// R02: A code write puts its glyph into display memory at the current digit.
// R03: Digit types: 7-seg 4x2, 14-seg 4x4, 16-seg 3x6 commons by segments.
// R04: First digit at configured start segment; reverse order decrements index.
// R05: After each character the index moves by the digit's segment count.
// R06: Auto mode bit zero is sequential, one is scrolling.
// R07: Sequential mode refreshes the configured digits once per display period.
// R08: Display period spans eight times counter value plus one frames.
// R09: Auto engine uses its selected frame counter, runs only when enabled.
// R10: Scrolling shows the same string one character further left each period.
// R11: Software sets steps to length minus digits plus one, DMA count multiple.
// R12: With reverse scrolling, start segment is the last glass character.
// R13: DMA feeds string characters and repeats its transfer to keep scrolling.
// R14: Sequential string length multiple of digits; restart DMA to repeat.
// R15: Bitmap word updates one memory byte at an offset; mask-one bits kept.
// R16: Bitmap size field sets the data writes forming one frame update.
// R17: DMA delivers size masked words before the shadow refresh.
// R18: Bitmap period is timed by its selected frame counter.
// R19: DMA transfers states times size words and restarts to repeat.
// R20: Display memory copied to shadow at each frame start unless locked.
// R21: Software disables a counter and sees it stopped before changing period.
// R22: Enabled engine requests one DMA word per expected word each period.
// R23: Glyph tables are constant patterns indexed by character code.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "lcdcm_defs.vh"

module lcdcm_top
(
	input wire ref_clk,
	input wire nrst,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire frame_start,
	output reg [159:0] shadow_mem,
	output reg acm_dma_req,
	output reg abm_dma_req
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [2:0] seg_per_digit;
		input [1:0] t;
		begin
			case (t)
				`LCDCM_T7: seg_per_digit = 3'h2;
				`LCDCM_T14: seg_per_digit = 3'h4;
				`LCDCM_T16: seg_per_digit = 3'h6;
				default: seg_per_digit = 3'h2;
			endcase
		end
	endfunction

	function [5:0] next_index;
		input [5:0] idx;
		input [1:0] t;
		input rev;
		begin
			if (rev)
				next_index = idx - {3'h0, seg_per_digit(t)}; // [R04] [R05]
			else
				next_index = idx + {3'h0, seg_per_digit(t)}; // [R05]
		end
	endfunction

	// Places a glyph: pattern bit c*n+j lands on common c, segment idx+j
	function [159:0] put_glyph;
		input [159:0] mem;
		input [17:0] pat;
		input [1:0] t;
		input [5:0] idx;
		integer c, j, n, s;
		begin
			put_glyph = mem;
			n = seg_per_digit(t);
			for (c = 0; c < `LCDCM_NCOM; c = c + 1)
				for (j = 0; j < 6; j = j + 1)
				begin
					s = idx + j;
					if (j < n && c * n + j < `LCDCM_PATW &&
						!(t == `LCDCM_T16 && c == 3) && s < `LCDCM_NSEG) // [R03]
						put_glyph[c * `LCDCM_NSEG + s] = pat[c * n + j];
				end
		end
	endfunction

	function [159:0] put_byte;
		input [159:0] mem;
		input [31:0] w;
		integer b;
		reg [7:0] keep;
		begin
			put_byte = mem;
			keep = w[`LCDCM_BD_MASK];
			if (w[`LCDCM_BD_OFF] < `LCDCM_NBYTE)
				for (b = 0; b < 8; b = b + 1)
					if (!keep[b]) // [R15]
						put_byte[w[`LCDCM_BD_OFF] * 8 + b] = w[b];
		end
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [2:0] fc_en_r;
	reg lock_r;
	reg [31:0] timing_r;
	reg [13:0] gcfg_r;
	reg [31:0] acfg_r;
	reg [12:0] bcfg_r;
	reg [5:0] man_idx_r;
	reg [159:0] disp_mem_r;
	reg [159:0] disp_mem_nxt;
	reg [7:0] fc_cnt_r [0:2];
	reg [8:0] acm_pend_r;
	reg [7:0] acm_skip_r;
	reg [7:0] acm_step_r;
	reg [5:0] acm_idx_r;
	reg acm_wait_r;
	reg [4:0] abm_pend_r;
	reg abm_wait_r;

	wire wr_ctrl = reg_wr && reg_addr == `LCDCM_A_CTRL;
	wire wr_tim = reg_wr && reg_addr == `LCDCM_A_TIMING;
	wire wr_gcfg = reg_wr && reg_addr == `LCDCM_A_GCFG;
	wire wr_code = reg_wr && reg_addr == `LCDCM_A_GCODE;
	wire wr_acfg = reg_wr && reg_addr == `LCDCM_A_ACFG;
	wire wr_adata = reg_wr && reg_addr == `LCDCM_A_ADATA;
	wire wr_bcfg = reg_wr && reg_addr == `LCDCM_A_BCFG;
	wire wr_bdata = reg_wr && reg_addr == `LCDCM_A_BDATA;

	wire acm_en = acfg_r[`LCDCM_AC_EN];
	wire acm_scroll = acfg_r[`LCDCM_AC_MODE]; // [R06]
	wire abm_en = bcfg_r[`LCDCM_AB_EN];
	wire acm_put = wr_adata && acm_pend_r != 9'h000 && acm_skip_r == 8'h00;

	// ----------------------------------------
	// Frame counters
	// ----------------------------------------
	wire [4:0] fc_val [0:2];
	wire [2:0] fc_roll;
	assign fc_val[0] = timing_r[`LCDCM_TIM_FC0];
	assign fc_val[1] = timing_r[`LCDCM_TIM_FC1];
	assign fc_val[2] = timing_r[`LCDCM_TIM_FC2];

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : fc
			// Last count is 8*(value+1)-1 frames
			assign fc_roll[g] = fc_en_r[g] && frame_start &&
				fc_cnt_r[g] == {fc_val[g], 3'h7}; // [R08]
			always @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
					fc_cnt_r[g] <= 8'h00;
				else if (!fc_en_r[g] || fc_roll[g])
					fc_cnt_r[g] <= 8'h00;
				else if (frame_start)
					fc_cnt_r[g] <= fc_cnt_r[g] + 8'h01;
			end
		end
	endgenerate

	wire acm_fc_sel = acfg_r[`LCDCM_AC_FCS] < 2'h3 &&
		fc_roll[acfg_r[`LCDCM_AC_FCS]];
	wire abm_fc_sel = bcfg_r[`LCDCM_AB_FCS] < 2'h3 &&
		fc_roll[bcfg_r[`LCDCM_AB_FCS]];
	wire acm_tick = acm_en && acm_fc_sel; // [R09]
	wire abm_tick = abm_en && abm_fc_sel; // [R18]

	// ----------------------------------------
	// Glyph lookup
	// ----------------------------------------
	wire [1:0] lk_type = wr_adata ? acfg_r[`LCDCM_AC_TYPE] :
		gcfg_r[`LCDCM_G_TYPE];
	wire [17:0] lk_pat;

	lcdcm_glyph u_glyph
	(
		.table_sel(gcfg_r[`LCDCM_G_TAB]),
		.digit_type(lk_type),
		.code(reg_wdata[`LCDCM_CODE]),
		.pattern(lk_pat)
	);

	// ----------------------------------------
	// Control and configuration
	// ----------------------------------------
	// Period changes take effect on the next count; software stops first
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			fc_en_r <= 3'h0;
			lock_r <= 1'b0;
			timing_r <= 32'h0000_0000;
			gcfg_r <= 14'h0000;
			acfg_r <= 32'h0000_0000;
			bcfg_r <= 13'h0000;
			man_idx_r <= 6'h00;
		end
		else
		begin
			if (wr_ctrl)
			begin
				fc_en_r <= reg_wdata[`LCDCM_CTRL_FCEN];
				lock_r <= reg_wdata[`LCDCM_CTRL_LOCK];
			end
			if (wr_tim)
				timing_r <= reg_wdata & 32'h001F_1F1F; // [R21]
			if (wr_acfg)
				acfg_r <= reg_wdata;
			if (wr_bcfg)
				bcfg_r <= reg_wdata[12:0];
			if (wr_gcfg)
			begin
				gcfg_r <= reg_wdata[13:0];
				man_idx_r <= reg_wdata[`LCDCM_G_SEG]; // [R04]
			end
			else if (wr_code)
				man_idx_r <= next_index(man_idx_r, gcfg_r[`LCDCM_G_TYPE],
					gcfg_r[`LCDCM_G_REV]); // [R05]
		end
	end

	// ----------------------------------------
	// Display memory
	// ----------------------------------------
	always @*
	begin
		disp_mem_nxt = disp_mem_r;
		if (wr_code)
			disp_mem_nxt = put_glyph(disp_mem_r, lk_pat,
				gcfg_r[`LCDCM_G_TYPE], man_idx_r); // [R02]
		if (acm_put)
			disp_mem_nxt = put_glyph(disp_mem_r, lk_pat,
				acfg_r[`LCDCM_AC_TYPE], acm_idx_r); // [R07] [R22]
		if (wr_bdata)
			disp_mem_nxt = put_byte(disp_mem_r, reg_wdata); // [R15]
	end

	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			disp_mem_r <= 160'h0;
			shadow_mem <= 160'h0;
		end
		else
		begin
			disp_mem_r <= disp_mem_nxt;
			// Lock keeps the glass steady while software rewrites memory
			if (frame_start && !lock_r)
				shadow_mem <= disp_mem_r; // [R20]
		end
	end

	// ----------------------------------------
	// Automated character engine
	// ----------------------------------------
	// Scrolling drops the first step words, so the glass window slides left
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			acm_pend_r <= 9'h000;
			acm_skip_r <= 8'h00;
			acm_step_r <= 8'h00;
			acm_idx_r <= 6'h00;
			acm_wait_r <= 1'b0;
			acm_dma_req <= 1'b0;
		end
		else if (!acm_en)
		begin
			acm_pend_r <= 9'h000;
			acm_skip_r <= 8'h00;
			acm_step_r <= 8'h00;
			acm_wait_r <= 1'b0;
			acm_dma_req <= 1'b0;
		end
		else if (acm_tick)
		begin
			acm_idx_r <= acfg_r[`LCDCM_AC_SEG]; // [R04] [R12]
			acm_wait_r <= 1'b0;
			acm_dma_req <= 1'b0;
			if (acm_scroll)
			begin
				acm_pend_r <= {5'h00, acfg_r[`LCDCM_AC_DIGIT_COUNT]} +
					{1'b0, acm_step_r}; // [R10]
				acm_skip_r <= acm_step_r;
				if (acm_step_r + 8'h01 >= acfg_r[`LCDCM_AC_STEPS])
					acm_step_r <= 8'h00; // [R11]
				else
					acm_step_r <= acm_step_r + 8'h01;
			end
			else
			begin
				acm_pend_r <= {5'h00, acfg_r[`LCDCM_AC_DIGIT_COUNT]}; // [R07]
				acm_skip_r <= 8'h00;
			end
		end
		else
		begin
			acm_dma_req <= 1'b0;
			if (wr_adata && acm_pend_r != 9'h000)
			begin
				acm_wait_r <= 1'b0;
				acm_pend_r <= acm_pend_r - 9'h001; // [R13]
				if (acm_skip_r != 8'h00)
					acm_skip_r <= acm_skip_r - 8'h01;
				else
					acm_idx_r <= next_index(acm_idx_r,
						acfg_r[`LCDCM_AC_TYPE], acfg_r[`LCDCM_AC_REV]); // [R05]
			end
			else if (!acm_wait_r && acm_pend_r != 9'h000)
			begin
				acm_dma_req <= 1'b1; // [R22]
				acm_wait_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Automated bit mapping engine
	// ----------------------------------------
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			abm_pend_r <= 5'h00;
			abm_wait_r <= 1'b0;
			abm_dma_req <= 1'b0;
		end
		else if (!abm_en)
		begin
			abm_pend_r <= 5'h00;
			abm_wait_r <= 1'b0;
			abm_dma_req <= 1'b0;
		end
		else if (abm_tick)
		begin
			abm_pend_r <= bcfg_r[`LCDCM_AB_SIZE]; // [R16] [R19]
			abm_wait_r <= 1'b0;
			abm_dma_req <= 1'b0;
		end
		else
		begin
			abm_dma_req <= 1'b0;
			if (wr_bdata && abm_pend_r != 5'h00)
			begin
				abm_wait_r <= 1'b0;
				abm_pend_r <= abm_pend_r - 5'h01; // [R17]
			end
			else if (!abm_wait_r && abm_pend_r != 5'h00)
			begin
				abm_dma_req <= 1'b1; // [R22]
				abm_wait_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				`LCDCM_A_CTRL: reg_rdata <= {28'h000_0000, lock_r, fc_en_r};
				`LCDCM_A_TIMING: reg_rdata <= timing_r;
				`LCDCM_A_STATUS: reg_rdata <= {11'h000, abm_pend_r,
					acm_pend_r[7:0], 5'h00, fc_en_r}; // [R21]
				`LCDCM_A_GCFG: reg_rdata <= {18'h0_0000, gcfg_r[13:6],
					man_idx_r};
				`LCDCM_A_ACFG: reg_rdata <= acfg_r;
				`LCDCM_A_BCFG: reg_rdata <= {19'h0_0000, bcfg_r};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end
		else
			reg_rdata <= 32'h0000_0000;
	end

endmodule // lcdcm_top

// >>> hdl/lcdcm_defs.vh
// Constants for the segment LCD character and bit mapper.
// Assumes a 32-bit register port with byte addresses on word boundaries.
`ifndef LCDCM_DEFS_VH
`define LCDCM_DEFS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define LCDCM_A_CTRL 8'h00
`define LCDCM_A_TIMING 8'h04
`define LCDCM_A_STATUS 8'h08
`define LCDCM_A_GCFG 8'h40
`define LCDCM_A_GCODE 8'h44
`define LCDCM_A_ACFG 8'h48
`define LCDCM_A_ADATA 8'h4C
`define LCDCM_A_BCFG 8'h50
`define LCDCM_A_BDATA 8'h54

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LCDCM_CTRL_FCEN 2:0
`define LCDCM_CTRL_LOCK 3
`define LCDCM_TIM_FC0 4:0
`define LCDCM_TIM_FC1 12:8
`define LCDCM_TIM_FC2 20:16
`define LCDCM_G_SEG 5:0
`define LCDCM_G_REV 8
`define LCDCM_G_TYPE 10:9
`define LCDCM_G_TAB 13:12
`define LCDCM_AC_EN 0
`define LCDCM_AC_FCS 2:1
`define LCDCM_AC_MODE 3
`define LCDCM_AC_REV 4
`define LCDCM_AC_TYPE 6:5
`define LCDCM_AC_SEG 13:8
`define LCDCM_AC_DIGIT_COUNT 19:16
`define LCDCM_AC_STEPS 31:24
`define LCDCM_AB_EN 0
`define LCDCM_AB_FCS 2:1
`define LCDCM_AB_SIZE 12:8
`define LCDCM_BD_DATA 7:0
`define LCDCM_BD_MASK 15:8
`define LCDCM_BD_OFF 20:16
`define LCDCM_CODE 6:0

// ----------------------------------------
// Encodings and geometry
// ----------------------------------------
`define LCDCM_T7 2'h0
`define LCDCM_T14 2'h1
`define LCDCM_T16 2'h2
`define LCDCM_NCOM 4
`define LCDCM_NSEG 40
`define LCDCM_NBYTE 20
`define LCDCM_MEMW 160
`define LCDCM_PATW 18

`endif

// >>> hdl/lcdcm_glyph.v
// Glyph lookup: character code to segment pattern, per table and digit type.
// Assumes purely combinational use by the mapper in the same clock domain.
`timescale 1ns/1ps
`include "lcdcm_defs.vh"

module lcdcm_glyph
(
	input wire [1:0] table_sel,
	input wire [1:0] digit_type,
	input wire [6:0] code,
	output reg [17:0] pattern
);

	// ----------------------------------------
	// Constant tables
	// ----------------------------------------
	// Base shapes in gfedcba order; letters only in tables 1 and up
	function [6:0] shape;
		input [6:0] c;
		input hex;
		begin
			case (c)
				7'h30: shape = 7'h3F;
				7'h31: shape = 7'h06;
				7'h32: shape = 7'h5B;
				7'h33: shape = 7'h4F;
				7'h34: shape = 7'h66;
				7'h35: shape = 7'h6D;
				7'h36: shape = 7'h7D;
				7'h37: shape = 7'h07;
				7'h38: shape = 7'h7F;
				7'h39: shape = 7'h6F;
				7'h41: shape = hex ? 7'h77 : 7'h00;
				7'h42: shape = hex ? 7'h7C : 7'h00;
				7'h43: shape = hex ? 7'h39 : 7'h00;
				7'h44: shape = hex ? 7'h5E : 7'h00;
				7'h45: shape = hex ? 7'h79 : 7'h00;
				7'h46: shape = hex ? 7'h71 : 7'h00;
				7'h2D: shape = 7'h40;
				default: shape = 7'h00;
			endcase
		end
	endfunction

	reg [6:0] base;
	reg [6:0] flip;
	integer i;

	always @*
	begin
		pattern = 18'h0_0000;
		base = shape(code, table_sel != 2'h0); // [R23]
		flip = shape(code, 1'b1);
		if (table_sel == 2'h2)
		begin
			for (i = 0; i < 7; i = i + 1)
				base[i] = flip[6 - i];
		end
		if (table_sel == 2'h3)
			base = code; // Raw test pattern
		case (digit_type) // [R01] [R03]
			`LCDCM_T7: pattern = {11'h000, base};
			`LCDCM_T14: pattern = {4'h0, base, base};
			`LCDCM_T16: pattern = {4'h0, base, base};
			default: pattern = 18'h0_0000;
		endcase
	end

endmodule // lcdcm_glyph

// >>> verification/lcdcm_props.sv
// Port checker for the character and bitmap mapper.
// Assumes binding to lcdcm_top; sees its ports only.
`timescale 1ns/1ps
module lcdcm_props
(
	input wire ref_clk,
	input wire nrst,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire frame_start,
	input wire [159:0] shadow_mem,
	input wire acm_dma_req,
	input wire abm_dma_req
);
reg [31:0] tim_r;
reg [7:0] bw_r;
default clocking @(posedge ref_clk); endclocking
default disable iff (!nrst);
// ------------------------------
// Shadow copies of written values
// ------------------------------
always @(posedge ref_clk or negedge nrst)
	if (!nrst)
	begin
		tim_r <= 32'h0000_0000;
		bw_r <= 8'h00;
	end
	else if (reg_wr && reg_addr == 8'h04)
		tim_r <= reg_wdata & 32'h001F_1F1F;
	else if (reg_wr && reg_addr == 8'h54)
		bw_r <= reg_wdata[7:0];
// ------------------------------
// Assertions
// ------------------------------
rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
	else $error("read data not zero outside read");
wo_read_zero_a: assert property (reg_rd && (reg_addr == 8'h44 ||
	reg_addr == 8'h4C || reg_addr == 8'h54 || reg_addr == 8'h3C)
	|=> reg_rdata == 32'h0000_0000) else $error("write-only read not zero");
timing_back_a: assert property (reg_rd && reg_addr == 8'h04
	|=> reg_rdata == tim_r) else $error("timing readback wrong");
shadow_frame_a: assert property (!$stable(shadow_mem) |->
	$past(frame_start)) else $error("shadow changed without frame");
bmap_apply_a: assert property (reg_wr && reg_addr == 8'h54 &&
	reg_wdata[20:8] == 13'h0300 ##2 frame_start |=> shadow_mem[31:24] == bw_r)
	else $error("bitmap byte not applied");
acm_pulse_a: assert property (acm_dma_req |=> !acm_dma_req)
	else $error("char request longer than a cycle");
abm_pulse_a: assert property (abm_dma_req |=> !abm_dma_req)
	else $error("bitmap request longer than a cycle");
req_cause_a: assert property (acm_dma_req |-> $past(frame_start) ||
	$past(frame_start, 2) || $past(reg_wr && reg_addr == 8'h4C)
	|| $past(reg_wr && reg_addr == 8'h4C, 2)) else $error("stray request");
cover property (acm_dma_req);
cover property (abm_dma_req);
cover property (frame_start ##1 !$stable(shadow_mem));
endmodule // lcdcm_props

bind lcdcm_top lcdcm_props i_lcdcm_props (.ref_clk(ref_clk), .nrst(nrst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(frame_start),
	.shadow_mem(shadow_mem), .acm_dma_req(acm_dma_req),
	.abm_dma_req(abm_dma_req));

// >>> verification/lcdcm_dma_model.sv
// DMA controller model: answers each request with one data word.
// Assumes the bench muxes its write onto the shared register port.
`timescale 1ns/1ps
module lcdcm_dma_model
(
	input wire ref_clk,
	input wire nrst,
	input wire acm_dma_req,
	input wire abm_dma_req,
	input wire slow,
	output reg dma_wr,
	output reg [7:0] dma_addr,
	output reg [31:0] dma_wdata
);
reg acm_p, abm_p;
reg [7:0] n_chr, n_bm;
reg [1:0] wait_r;
// Char words first; one strobe per cycle so the two never collide
always @(posedge ref_clk or negedge nrst)
	if (!nrst)
	begin
		{dma_wr, acm_p, abm_p, wait_r} <= 5'h00;
		{n_chr, n_bm} <= 16'h0000;
		dma_addr <= 8'h00;
		dma_wdata <= 32'h0000_0000;
	end
	else
	begin
		if (acm_dma_req)
			acm_p <= 1'b1;
		if (abm_dma_req)
			abm_p <= 1'b1;
		if (wait_r != 2'h0)
		begin
			wait_r <= wait_r - 2'h1;
			dma_wr <= 1'b0;
		end
		else if (acm_p && !dma_wr)
		begin
			dma_wr <= 1'b1;
			dma_addr <= 8'h4C;
			dma_wdata <= {29'h0, n_chr[2:0]} | 32'h0000_0030;
			n_chr <= n_chr + 8'h01;
			acm_p <= 1'b0;
			wait_r <= slow ? 2'h3 : 2'h0;
		end
		else if (abm_p && !dma_wr)
		begin
			dma_wr <= 1'b1;
			dma_addr <= 8'h54;
			dma_wdata <= {11'h0, 5'h05, 8'h00, n_bm};
			n_bm <= n_bm + 8'h01;
			abm_p <= 1'b0;
		end
		else
			dma_wr <= 1'b0;
	end
endmodule // lcdcm_dma_model

// >>> verification/lcdcm_top_tb_top.sv
// Self-checking bench for the mapper: register tasks plus a DMA model.
// Assumes the design and its bound checker are compiled first.
`timescale 1ns/1ps
module lcdcm_top_tb_top;
reg ref_clk, nrst, tb_wr, tb_rd, frame_start, slow;
reg [7:0] tb_addr;
reg [31:0] tb_wdata, d, snap;
reg [159:0] s;
wire dma_wr, acm_dma_req, abm_dma_req;
wire [7:0] dma_addr;
wire [31:0] dma_wdata, reg_rdata;
wire [159:0] shadow_mem;
integer errors, n_compared, n_acm, n_abm, i, t, typ, stp, b;
lcdcm_top i_lcdcm_top (.ref_clk(ref_clk), .nrst(nrst),
	.reg_addr(dma_wr ? dma_addr : tb_addr),
	.reg_wdata(dma_wr ? dma_wdata : tb_wdata), .reg_wr(tb_wr | dma_wr),
	.reg_rd(tb_rd & !dma_wr), .reg_rdata(reg_rdata),
	.frame_start(frame_start), .shadow_mem(shadow_mem),
	.acm_dma_req(acm_dma_req), .abm_dma_req(abm_dma_req));
lcdcm_dma_model i_lcdcm_dma_model (.ref_clk(ref_clk), .nrst(nrst),
	.acm_dma_req(acm_dma_req), .abm_dma_req(abm_dma_req), .slow(slow),
	.dma_wr(dma_wr), .dma_addr(dma_addr), .dma_wdata(dma_wdata));
// ------------------------------
// Bus, frame and compare tasks
// ------------------------------
task wr(input [7:0] a, input [31:0] v);
	@(posedge ref_clk);
	tb_wr <= 1'b1;
	tb_addr <= a;
	tb_wdata <= v;
	@(posedge ref_clk);
	tb_wr <= 1'b0;
endtask
task rd(input [7:0] a, output [31:0] v);
	@(posedge ref_clk);
	tb_rd <= 1'b1;
	tb_addr <= a;
	@(posedge ref_clk);
	tb_rd <= 1'b0;
	#1 v = reg_rdata;
endtask
// Gap after each frame lets the DMA model finish its words
task frames(input integer n);
	repeat (n)
	begin
		@(posedge ref_clk);
		frame_start <= 1'b1;
		@(posedge ref_clk);
		frame_start <= 1'b0;
		repeat (20) @(posedge ref_clk);
	end
	s = shadow_mem;
endtask
task chk(input [31:0] got, input [31:0] exp, input [8*12-1:0] what);
	n_compared = n_compared + 1;
	if (got !== exp)
	begin
		errors = errors + 1;
		$display("BAD %0t %0s got %h exp %h", $time, what, got, exp);
	end
endtask
task report_and_stop;
	$display("compared %0d mismatches %0d", n_compared, errors);
	if (errors == 0 && n_compared > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask
always @(posedge ref_clk)
	if (!nrst)
	begin
		n_acm <= 0;
		n_abm <= 0;
	end
	else
	begin
		n_acm <= n_acm + acm_dma_req;
		n_abm <= n_abm + abm_dma_req;
	end
initial
begin
	ref_clk = 1'b0;
	forever #25 ref_clk = ~ref_clk;
end
initial
begin
	repeat (20000) @(posedge ref_clk);
	errors = errors + 1;
	report_and_stop;
end
// ------------------------------
// Test sequence
// ------------------------------
initial
begin
	{nrst, tb_wr, tb_rd, frame_start, slow} = 5'h00;
	tb_addr = 8'h00;
	tb_wdata = 32'h0000_0000;
	{errors, n_compared} = 0;
	repeat (6) @(posedge ref_clk);
	nrst <= 1'b1;
	rd(8'h04, d); chk(d, 32'h0000_0000, "tim reset");
	wr(8'h04, 32'h0002_0100);
	rd(8'h04, d); chk(d, 32'h0002_0100, "tim");
	rd(8'h3C, d); chk(d, 32'h0000_0000, "unmapped");
	wr(8'h00, 32'h0000_0003);
	rd(8'h08, d); chk(d & 32'h0000_0007, 32'h0000_0003, "running");
	$display("registers done");
	for (i = 0; i < 8; i = i + 1)
	begin
		t = i % 4;
		typ = (t == 3) ? 0 : t;
		stp = (typ == 0) ? 2 : (typ == 1) ? 4 : 6;
		wr(8'h40, (t << 12) | (typ << 9) | ((i / 4) << 8) | 20);
		wr(8'h44, 32'h0000_0038);
		rd(8'h40, d); chk(d & 32'h0000_003F, (i < 4) ? 20 + stp : 20 - stp, "index");
	end
	wr(8'h40, 32'h0000_0000);
	wr(8'h44, 32'h0000_0038);
	frames(1);
	chk({s[121:120], s[81:80], s[41:40], s[1:0]}, 32'h0000_007F, "glyph");
	chk(s[7:2], 0, "glyph edge");
	$display("glyph done");
	wr(8'h54, 32'h0003_00FF);
	frames(1); chk(s[31:24], 32'h0000_00FF, "bmap");
	wr(8'h54, 32'h0003_F000);
	frames(1); chk(s[31:24], 32'h0000_00F0, "bmap mask");
	snap = s[31:0];
	wr(8'h54, 32'h0014_00FF);
	frames(1); chk(s[31:0], snap, "bmap off");
	wr(8'h00, 32'h0000_000B);
	wr(8'h54, 32'h0003_0000);
	repeat (3) @(posedge ref_clk);
	frames(1); chk(s[31:24], 32'h0000_00F0, "locked");
	wr(8'h00, 32'h0000_0003);
	frames(1); chk(s[31:24], 32'h0000_0000, "unlocked");
	$display("bitmap done");
	wr(8'h00, 32'h0000_0000);
	wr(8'h48, 32'h0003_0A01);
	wr(8'h00, 32'h0000_0001);
	b = n_acm;
	frames(7); chk(n_acm - b, 0, "seq early");
	frames(1); chk(n_acm - b, 3, "seq reqs");
	slow <= 1'b1;
	frames(8); chk(n_acm - b, 6, "seq slow");
	chk(s[15:10], 32'h0000_003B, "seq glyphs");
	slow <= 1'b0;
	wr(8'h00, 32'h0000_0000);
	wr(8'h48, 32'h0202_0A19);
	wr(8'h00, 32'h0000_0001);
	b = n_acm;
	for (i = 0; i < 3; i = i + 1)
	begin
		frames(8);
		chk(n_acm - b, (i == 1) ? 3 : 2, "scroll");
		b = n_acm;
	end
	wr(8'h48, 32'h0000_0000);
	$display("char engine done");
	wr(8'h00, 32'h0000_0002);
	wr(8'h50, 32'h0000_0203);
	b = n_abm;
	frames(15); chk(n_abm - b, 0, "abm early");
	frames(1); chk(n_abm - b, 2, "abm reqs");
	frames(1); chk(s[47:40], 32'h0000_0001, "abm data");
	$display("bitmap engine done");
	report_and_stop;
end
endmodule // lcdcm_top_tb_top
